// File: qsh_top.sv
// quad serial host block: status and command bytes, clocks, channel registers
// Functional notes
// - each channel: 16-bit down counter, square-wave output
// - new time constant used only at reload
// - time constant write taken without synchronisation
// - constant = ref/(2*bitclock) - 2
// - divisor bytes writable and readable back
// - 16 write, 9 read registers; two shared
// - pending via A; modified vector via B
// - status byte returned on transmit-status command
// - status bit 1 selects self-test meaning
// - normal: busy, address missing, vector missing
// - self-test: fatal, set, ROM, DMA failures
// - bits 4-7 report channel DSR, active low
// - bits 0-3 block ready; bit 7 inhibit
// - bits 5:4 select port; bit 6 resets
// - buffer 8 MHz bus clock, derive 4 MHz
// - host reference clock drives all baud rates
// - receive/transmit buffers; status follows characters
// - host polls busy before next word
// - reset defaults 7 bits odd 9600
`timescale 1ns/100ps
`default_nettype none
module qsh_top #(
    parameter int NCH = qsh_pkg::NCH,
    parameter int TCW = 16
) (
    input  wire logic                    CLK,          // 200 MHz system clock
    input  wire logic                    NRST,         // sync reset, active low
    input  wire logic                    CE,           // clock enable
    input  wire logic                    BUS_IO_CLK,   // 8 MHz bus clock pin
    input  wire logic                    BAUD_REF_CLK, // 3.6864 MHz reference pin
    input  wire logic [NCH-1:0]          DSR_N,        // data set ready pins, low true
    input  wire logic                    STATUS_REQ,   // transmit-status command
    output logic [7:0]                   STATUS_DATA,  // status byte to host
    output logic                         STATUS_VALID, // status byte strobe
    input  wire qsh_pkg::qsh_fw_status_s FW_STATUS,    // firmware status flags
    input  wire logic                    INSTR_WE,     // host command byte write
    input  wire logic [7:0]              INSTR_DATA,   // host command byte
    output logic [NCH-1:0]               CB_READY,     // command block ready flags
    input  wire logic [NCH-1:0]          CB_ACK,       // firmware clears ready flag
    output logic                         INT_INHIBIT,  // interrupt inhibit level
    output logic [NCH-1:0]               PORT_RESET,   // port reset pulse
    output logic [NCH-1:0]               XON_RELEASE,  // flow-control release pulse
    output logic                         PROC_CLK,     // derived 4 MHz clock
    input  wire qsh_pkg::qsh_reg_req_s   REG_REQ,      // channel register access
    output logic [7:0]                   REG_RDATA,    // register read data
    output logic                         REG_RVALID,   // read data strobe
    input  wire logic [NCH-1:0]          RX_VALID,     // character received
    input  wire logic [NCH-1:0][7:0]     RX_DATA,      // received character
    input  wire logic [NCH-1:0]          TX_DONE,      // character sent
    output logic [NCH-1:0]               TX_LOAD,      // transmit buffer written
    output logic [NCH-1:0][7:0]          TX_DATA,      // transmit character
    output logic [NCH-1:0][2:0][7:0]     LINE_CFG,     // rx, mode, tx parameters
    output logic [NCH-1:0]               BAUD_CLK      // x16 baud clocks
);
    localparam int NS = NCH + 2;

    // three-stage pin synchronisers, filtered on stage 2/3 agreement
    logic [NS-1:0] s1_reg, s2_reg, s3_reg, filt_reg, fprev_reg;
    logic [NS-1:0] s1_next, s2_next, s3_next, filt_next, fprev_next;
    logic          ref_tick;
    logic          bus_rise;
    logic [NCH-1:0] dsr_n_sync;

    always_comb begin
        s1_next    = {DSR_N, BUS_IO_CLK, BAUD_REF_CLK};
        s2_next    = s1_reg;
        s3_next    = s2_reg;
        filt_next  = (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
        fprev_next = filt_reg;
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            s1_reg    <= '0;
            s2_reg    <= '0;
            s3_reg    <= '0;
            filt_reg  <= '0;
            fprev_reg <= '0;
        end else if (CE) begin
            s1_reg    <= s1_next;
            s2_reg    <= s2_next;
            s3_reg    <= s3_next;
            filt_reg  <= filt_next;
            fprev_reg <= fprev_next;
        end
    end

    assign ref_tick   = filt_reg[0] & ~fprev_reg[0];
    assign bus_rise   = filt_reg[1] & ~fprev_reg[1];
    assign dsr_n_sync = filt_reg[NS-1:2];

    // host-facing status and command bytes
    logic [7:0]     stat_reg, stat_next;
    logic           sval_reg, sval_next;
    logic [NCH-1:0] cbr_reg, cbr_next;
    logic           inh_reg, inh_next;
    logic [NCH-1:0] prst_reg, prst_next;
    logic [NCH-1:0] xon_reg, xon_next;
    logic           proc_reg, proc_next;
    logic [NCH-1:0] port_sel;

    assign port_sel = qsh_pkg::qsh_onehot4(INSTR_DATA[qsh_pkg::IN_PORT_LSB +: 2]);

    always_comb begin
        stat_next = stat_reg;
        sval_next = STATUS_REQ;
        if (STATUS_REQ) begin
            stat_next[qsh_pkg::ST_DSR_LSB +: NCH] = dsr_n_sync;
            if (FW_STATUS.self_test) begin
                stat_next[qsh_pkg::ST_FATAL]    = FW_STATUS.fatal | FW_STATUS.rom_fail | FW_STATUS.dma_fail;
                stat_next[qsh_pkg::ST_SELFTEST] = 1'b1;
                stat_next[qsh_pkg::ST_ROM]      = FW_STATUS.rom_fail;
                stat_next[qsh_pkg::ST_DMA]      = FW_STATUS.dma_fail;
            end else begin
                stat_next[qsh_pkg::ST_BUSY]     = FW_STATUS.busy;
                stat_next[qsh_pkg::ST_SELFTEST] = 1'b0;
                stat_next[qsh_pkg::ST_CBA]      = FW_STATUS.cba_missing;
                stat_next[qsh_pkg::ST_VECMISS]  = FW_STATUS.vec_missing;
            end
        end
        // a new ready bit in the same cycle as its acknowledge is kept
        cbr_next  = cbr_reg & ~CB_ACK;
        inh_next  = inh_reg;
        prst_next = '0;
        xon_next  = '0;
        if (INSTR_WE) begin
            cbr_next = cbr_next | INSTR_DATA[qsh_pkg::IN_CBR_LSB +: NCH];
            inh_next = INSTR_DATA[qsh_pkg::IN_INH_BIT];
            xon_next = port_sel;
            if (INSTR_DATA[qsh_pkg::IN_RST_BIT]) begin
                prst_next = port_sel;
            end
        end
        proc_next = bus_rise ? ~proc_reg : proc_reg;
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            stat_reg <= 8'h00;
            sval_reg <= 1'b0;
            cbr_reg  <= '0;
            inh_reg  <= 1'b0;
            prst_reg <= '0;
            xon_reg  <= '0;
            proc_reg <= 1'b0;
        end else if (CE) begin
            stat_reg <= stat_next;
            sval_reg <= sval_next;
            cbr_reg  <= cbr_next;
            inh_reg  <= inh_next;
            prst_reg <= prst_next;
            xon_reg  <= xon_next;
            proc_reg <= proc_next;
        end
    end

    // channel register file
    logic [7:0]     wr_reg [NCH][qsh_pkg::NREG];
    logic [7:0]     wr_next[NCH][qsh_pkg::NREG];
    logic [7:0]     vec_reg [qsh_pkg::NCTL];
    logic [7:0]     vec_next[qsh_pkg::NCTL];
    logic [7:0]     mic_reg [qsh_pkg::NCTL];
    logic [7:0]     mic_next[qsh_pkg::NCTL];
    logic [NCH-1:0][7:0] rxbuf_reg, rxbuf_next, txd_reg, txd_next;
    logic [NCH-1:0] rxav_reg, rxav_next, txe_reg, txe_next, txl_reg, txl_next;
    logic [NCH-1:0] chan_rst;
    logic [1:0]     mic_cmd;
    logic           req_wr_mic;
    logic           req_rd_buf;

    assign req_wr_mic = REG_REQ.wr && (REG_REQ.idx == qsh_pkg::WI_MIC);
    assign req_rd_buf = REG_REQ.rd && (REG_REQ.idx == qsh_pkg::RI_BUF);
    assign mic_cmd    = REG_REQ.wdata[qsh_pkg::MIC_RST_LSB +: 2];

    always_comb begin
        chan_rst = port_sel & {NCH{INSTR_WE & INSTR_DATA[qsh_pkg::IN_RST_BIT]}};
        if (req_wr_mic) begin
            if (mic_cmd == qsh_pkg::MIC_RST_BOTH || mic_cmd == qsh_pkg::MIC_RST_A) begin
                chan_rst[{REG_REQ.chan[1], 1'b0}] = 1'b1;
            end
            if (mic_cmd == qsh_pkg::MIC_RST_BOTH || mic_cmd == qsh_pkg::MIC_RST_B) begin
                chan_rst[{REG_REQ.chan[1], 1'b1}] = 1'b1;
            end
        end
    end

    always_comb begin
        wr_next    = wr_reg;
        vec_next   = vec_reg;
        mic_next   = mic_reg;
        rxbuf_next = rxbuf_reg;
        txd_next   = txd_reg;
        rxav_next  = rxav_reg;
        txe_next   = txe_reg;
        txl_next   = '0;
        for (int k = 0; k < qsh_pkg::NCTL; k++) begin
            if (REG_REQ.wr && REG_REQ.chan[1] == k[0] && REG_REQ.idx == qsh_pkg::WI_VEC) begin
                vec_next[k] = REG_REQ.wdata;
            end
            if (req_wr_mic && REG_REQ.chan[1] == k[0]) begin
                // reset command bits act once and are not kept
                mic_next[k] = {2'h0, REG_REQ.wdata[qsh_pkg::MIC_RST_LSB-1:0]};
            end
        end
        for (int c = 0; c < NCH; c++) begin
            if (chan_rst[c]) begin
                for (int r = 0; r < qsh_pkg::NREG; r++) begin
                    wr_next[c][r] = qsh_pkg::qsh_def_wr(r[3:0]);
                end
                rxav_next[c] = 1'b0;
                txe_next[c]  = 1'b1;
            end else begin
                if (REG_REQ.wr && REG_REQ.chan == c[1:0]) begin
                    if (REG_REQ.idx == qsh_pkg::WI_BUF) begin
                        txd_next[c] = REG_REQ.wdata;
                        txl_next[c] = 1'b1;
                        txe_next[c] = 1'b0;
                    end else if (REG_REQ.idx != qsh_pkg::WI_VEC && REG_REQ.idx != qsh_pkg::WI_MIC) begin
                        wr_next[c][REG_REQ.idx] = REG_REQ.wdata;
                    end
                end
                if (req_rd_buf && REG_REQ.chan == c[1:0]) begin
                    rxav_next[c] = 1'b0;
                end
                // hardware events are applied after the clears so they win
                if (RX_VALID[c]) begin
                    rxbuf_next[c] = RX_DATA[c];
                    rxav_next[c]  = 1'b1;
                end
                if (TX_DONE[c]) begin
                    txe_next[c] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            for (int c = 0; c < NCH; c++) begin
                for (int r = 0; r < qsh_pkg::NREG; r++) begin
                    wr_reg[c][r] <= qsh_pkg::qsh_def_wr(r[3:0]);
                end
            end
            for (int k = 0; k < qsh_pkg::NCTL; k++) begin
                vec_reg[k] <= 8'h00;
                mic_reg[k] <= 8'h00;
            end
            rxbuf_reg <= '0;
            txd_reg   <= '0;
            rxav_reg  <= '0;
            txe_reg   <= '1;
            txl_reg   <= '0;
        end else if (CE) begin
            wr_reg    <= wr_next;
            vec_reg   <= vec_next;
            mic_reg   <= mic_next;
            rxbuf_reg <= rxbuf_next;
            txd_reg   <= txd_next;
            rxav_reg  <= rxav_next;
            txe_reg   <= txe_next;
            txl_reg   <= txl_next;
        end
    end

    // interrupt pending and vector views per controller
    logic [7:0] pend  [qsh_pkg::NCTL];
    logic [7:0] modvec[qsh_pkg::NCTL];

    always_comb begin
        for (int k = 0; k < qsh_pkg::NCTL; k++) begin
            pend[k] = 8'h00;
            if (mic_reg[k][qsh_pkg::MIC_MIE_BIT]) begin
                pend[k][qsh_pkg::PEND_A_RX_BIT] = rxav_reg[2*k]   & wr_reg[2*k][qsh_pkg::WI_INTEN][qsh_pkg::INTEN_RX_BIT];
                pend[k][qsh_pkg::PEND_A_TX_BIT] = txe_reg[2*k]    & wr_reg[2*k][qsh_pkg::WI_INTEN][qsh_pkg::INTEN_TX_BIT];
                pend[k][qsh_pkg::PEND_B_RX_BIT] = rxav_reg[2*k+1] & wr_reg[2*k+1][qsh_pkg::WI_INTEN][qsh_pkg::INTEN_RX_BIT];
                pend[k][qsh_pkg::PEND_B_TX_BIT] = txe_reg[2*k+1]  & wr_reg[2*k+1][qsh_pkg::WI_INTEN][qsh_pkg::INTEN_TX_BIT];
            end
            modvec[k] = vec_reg[k];
            if (pend[k][qsh_pkg::PEND_A_RX_BIT]) begin
                modvec[k][qsh_pkg::VEC_CODE_LSB +: 3] = qsh_pkg::VC_A_RX;
            end else if (pend[k][qsh_pkg::PEND_A_TX_BIT]) begin
                modvec[k][qsh_pkg::VEC_CODE_LSB +: 3] = qsh_pkg::VC_A_TX;
            end else if (pend[k][qsh_pkg::PEND_B_RX_BIT]) begin
                modvec[k][qsh_pkg::VEC_CODE_LSB +: 3] = qsh_pkg::VC_B_RX;
            end else if (pend[k][qsh_pkg::PEND_B_TX_BIT]) begin
                modvec[k][qsh_pkg::VEC_CODE_LSB +: 3] = qsh_pkg::VC_B_TX;
            end else begin
                modvec[k][qsh_pkg::VEC_CODE_LSB +: 3] = qsh_pkg::VC_NONE;
            end
        end
    end

    // read port: one registered answer per read strobe
    logic [7:0] rdat_reg, rdat_next;
    logic       rval_reg, rval_next;
    logic       is_chan_b;
    logic       ctl;

    assign is_chan_b = REG_REQ.chan[0];
    assign ctl       = REG_REQ.chan[1];

    always_comb begin
        rdat_next = rdat_reg;
        rval_next = REG_REQ.rd;
        if (REG_REQ.rd) begin
            case (REG_REQ.idx)
                qsh_pkg::RI_STAT: begin
                    rdat_next = 8'h00;
                    rdat_next[qsh_pkg::RR0_RXAV_BIT] = rxav_reg[REG_REQ.chan];
                    rdat_next[qsh_pkg::RR0_TXE_BIT]  = txe_reg[REG_REQ.chan];
                end
                qsh_pkg::RI_VEC:  rdat_next = is_chan_b ? modvec[ctl] : vec_reg[ctl];
                qsh_pkg::RI_PEND: rdat_next = is_chan_b ? 8'h00 : pend[ctl];
                qsh_pkg::RI_BUF:  rdat_next = rxbuf_reg[REG_REQ.chan];
                qsh_pkg::RI_TCL:  rdat_next = wr_reg[REG_REQ.chan][qsh_pkg::WI_TCL];
                qsh_pkg::RI_TCH:  rdat_next = wr_reg[REG_REQ.chan][qsh_pkg::WI_TCH];
                qsh_pkg::RI_EXT:  rdat_next = wr_reg[REG_REQ.chan][qsh_pkg::WI_EXT];
                default:          rdat_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            rdat_reg <= 8'h00;
            rval_reg <= 1'b0;
        end else if (CE) begin
            rdat_reg <= rdat_next;
            rval_reg <= rval_next;
        end
    end

    // baud generators, all fed from the one reference tick
    for (genvar g = 0; g < NCH; g++) begin : g_brg
        qsh_baud_gen #(
            .WIDTH (TCW)
        ) u_brg (
            .clk     (CLK),
            .nrst    (NRST),
            .ce      (CE),
            .enable  (wr_reg[g][qsh_pkg::WI_MISC][qsh_pkg::MISC_BRG_EN_BIT]),
            .tick    (ref_tick),
            .tc      ({wr_reg[g][qsh_pkg::WI_TCH], wr_reg[g][qsh_pkg::WI_TCL]}),
            .clk_out (BAUD_CLK[g])
        );
        assign LINE_CFG[g] = {wr_reg[g][qsh_pkg::WI_TXP], wr_reg[g][qsh_pkg::WI_MODE], wr_reg[g][qsh_pkg::WI_RXP]};
    end

    assign STATUS_DATA  = stat_reg;
    assign STATUS_VALID = sval_reg;
    assign CB_READY     = cbr_reg;
    assign INT_INHIBIT  = inh_reg;
    assign PORT_RESET   = prst_reg;
    assign XON_RELEASE  = xon_reg;
    assign PROC_CLK     = proc_reg;
    assign REG_RDATA    = rdat_reg;
    assign REG_RVALID   = rval_reg;
    assign TX_LOAD      = txl_reg;
    assign TX_DATA      = txd_reg;
endmodule
`default_nettype wire

// File: qsh_pkg.sv
// shared constants, types and helpers for the quad serial host block
package qsh_pkg;

    localparam int NCH         = 4;
    localparam int NCTL        = 2;
    localparam int NREG        = 16;
    localparam int SYNC_STAGES = 3;

    // clock rates, kept for the divisor arithmetic that software performs
    localparam int REF_CLK_HZ  = 3686400;
    localparam int SYS_CLK_HZ  = 200000000;
    localparam int OVERSAMPLE  = 16;

    // read register indices
    localparam logic [3:0] RI_STAT = 4'h0;
    localparam logic [3:0] RI_SPEC = 4'h1;
    localparam logic [3:0] RI_VEC  = 4'h2;
    localparam logic [3:0] RI_PEND = 4'h3;
    localparam logic [3:0] RI_BUF  = 4'h8;
    localparam logic [3:0] RI_MISC = 4'ha;
    localparam logic [3:0] RI_TCL  = 4'hc;
    localparam logic [3:0] RI_TCH  = 4'hd;
    localparam logic [3:0] RI_EXT  = 4'hf;

    // write register indices
    localparam logic [3:0] WI_INTEN = 4'h1;
    localparam logic [3:0] WI_VEC   = 4'h2;
    localparam logic [3:0] WI_RXP   = 4'h3;
    localparam logic [3:0] WI_MODE  = 4'h4;
    localparam logic [3:0] WI_TXP   = 4'h5;
    localparam logic [3:0] WI_BUF   = 4'h8;
    localparam logic [3:0] WI_MIC   = 4'h9;
    localparam logic [3:0] WI_TCL   = 4'hc;
    localparam logic [3:0] WI_TCH   = 4'hd;
    localparam logic [3:0] WI_MISC  = 4'he;
    localparam logic [3:0] WI_EXT   = 4'hf;

    // field positions
    localparam int MISC_BRG_EN_BIT = 0;
    localparam int INTEN_TX_BIT    = 1;
    localparam int INTEN_RX_BIT    = 4;
    localparam int MIC_MIE_BIT     = 3;
    localparam int MIC_RST_LSB     = 6;
    localparam int RR0_RXAV_BIT    = 0;
    localparam int RR0_TXE_BIT     = 2;
    localparam int PEND_A_RX_BIT   = 5;
    localparam int PEND_A_TX_BIT   = 4;
    localparam int PEND_B_RX_BIT   = 2;
    localparam int PEND_B_TX_BIT   = 1;
    localparam int VEC_CODE_LSB    = 1;

    localparam int ST_BUSY     = 0;
    localparam int ST_FATAL    = 0;
    localparam int ST_SELFTEST = 1;
    localparam int ST_CBA      = 2;
    localparam int ST_ROM      = 2;
    localparam int ST_VECMISS  = 3;
    localparam int ST_DMA      = 3;
    localparam int ST_DSR_LSB  = 4;

    localparam int IN_CBR_LSB  = 0;
    localparam int IN_PORT_LSB = 4;
    localparam int IN_RST_BIT  = 6;
    localparam int IN_INH_BIT  = 7;

    // master interrupt reset commands
    localparam logic [1:0] MIC_RST_NONE = 2'h0;
    localparam logic [1:0] MIC_RST_B    = 2'h1;
    localparam logic [1:0] MIC_RST_A    = 2'h2;
    localparam logic [1:0] MIC_RST_BOTH = 2'h3;

    // vector status codes placed in bits 3:1 of the modified vector
    localparam logic [2:0] VC_B_TX = 3'h0;
    localparam logic [2:0] VC_B_RX = 3'h2;
    localparam logic [2:0] VC_NONE = 3'h3;
    localparam logic [2:0] VC_A_TX = 3'h4;
    localparam logic [2:0] VC_A_RX = 3'h6;

    // reset defaults: 7 data bits, odd parity, one stop, x16, 9600 baud
    localparam logic [7:0] DEF_RXP  = 8'h81;
    localparam logic [7:0] DEF_MODE = 8'h45;
    localparam logic [7:0] DEF_TXP  = 8'h48;
    localparam logic [7:0] DEF_TCL  = 8'h0a;
    localparam logic [7:0] DEF_TCH  = 8'h00;
    localparam logic [7:0] DEF_MISC = 8'h01;
    localparam logic [7:0] DEF_ZERO = 8'h00;

    typedef struct packed {
        logic self_test;
        logic busy;
        logic cba_missing;
        logic vec_missing;
        logic fatal;
        logic rom_fail;
        logic dma_fail;
    } qsh_fw_status_s;

    typedef struct packed {
        logic [1:0] chan;
        logic [3:0] idx;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } qsh_reg_req_s;

    function automatic logic [3:0] qsh_onehot4(input logic [1:0] sel);
        logic [3:0] r;
        r = 4'h0;
        r[sel] = 1'b1;
        return r;
    endfunction

    function automatic logic [7:0] qsh_def_wr(input logic [3:0] idx);
        logic [7:0] r;
        case (idx)
            WI_RXP:  r = DEF_RXP;
            WI_MODE: r = DEF_MODE;
            WI_TXP:  r = DEF_TXP;
            WI_TCL:  r = DEF_TCL;
            WI_TCH:  r = DEF_TCH;
            WI_MISC: r = DEF_MISC;
            default: r = DEF_ZERO;
        endcase
        return r;
    endfunction

endpackage

// File: qsh_baud_gen.sv
// per-channel baud generator: down counter with square-wave output
`timescale 1ns/100ps
`default_nettype none
module qsh_baud_gen #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,     // system clock
    input  wire logic             nrst,    // sync reset, active low
    input  wire logic             ce,      // clock enable
    input  wire logic             enable,  // generator run enable
    input  wire logic             tick,    // reference clock rising edge
    input  wire logic [WIDTH-1:0] tc,      // time constant
    output logic                  clk_out  // square-wave output
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic             load_reg;
    logic             load_next;
    logic             out_reg;
    logic             out_next;

    // one load tick plus tc+1 count ticks gives a half period of tc+2
    always_comb begin
        count_next = count_reg;
        load_next  = load_reg;
        out_next   = out_reg;
        if (!enable) begin
            count_next = tc;
            load_next  = 1'b0;
        end else if (tick) begin
            if (load_reg) begin
                count_next = tc;
                load_next  = 1'b0;
            end else if (count_reg == '0) begin
                load_next = 1'b1;
                out_next  = ~out_reg;
            end else begin
                count_next = count_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            count_reg <= '0;
            load_reg  <= 1'b0;
            out_reg   <= 1'b0;
        end else if (ce) begin
            count_reg <= count_next;
            load_reg  <= load_next;
            out_reg   <= out_next;
        end
    end

    assign clk_out = out_reg;
endmodule
`default_nettype wire

// File: qsh_top_asserts.sv
// port checker for the quad serial host block
`timescale 1ns/100ps
`default_nettype none
module qsh_top_asserts #(
    parameter int NCH = 4
) (
    input wire logic                   CLK,          // clock
    input wire logic                   NRST,         // sync reset, low
    input wire logic                   CE,           // clock enable
    input wire logic                   STATUS_REQ,   // status command
    input wire logic [7:0]             STATUS_DATA,  // status byte
    input wire logic                   STATUS_VALID, // status strobe
    input wire qsh_pkg::qsh_fw_status_s FW_STATUS,   // firmware flags
    input wire logic                   INSTR_WE,     // command write
    input wire logic [7:0]             INSTR_DATA,   // command byte
    input wire logic [NCH-1:0]         CB_READY,     // ready flags
    input wire logic                   INT_INHIBIT,  // inhibit level
    input wire logic [NCH-1:0]         PORT_RESET,   // reset pulses
    input wire logic [NCH-1:0]         XON_RELEASE   // release pulses
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    sequence s_req; CE && STATUS_REQ; endsequence
    sequence s_cmd; CE && INSTR_WE; endsequence
    a_status_strobe: assert property (s_req |=> STATUS_VALID) else $error("status strobe missing");
    a_status_mode: assert property (s_req |=> STATUS_DATA[1] == $past(FW_STATUS.self_test))
        else $error("mode bit wrong");
    a_status_normal: assert property (s_req ##1 !STATUS_DATA[1] |-> STATUS_DATA[3:0] ==
        {$past(FW_STATUS.vec_missing), $past(FW_STATUS.cba_missing), 1'b0, $past(FW_STATUS.busy)})
        else $error("normal status wrong");
    a_status_selftest: assert property (s_req ##1 STATUS_DATA[1] |-> STATUS_DATA[3:2] ==
        {$past(FW_STATUS.dma_fail), $past(FW_STATUS.rom_fail)}) else $error("self-test status wrong");
    a_cmd_ready: assert property (s_cmd |=> (CB_READY & $past(INSTR_DATA[3:0])) == $past(INSTR_DATA[3:0]))
        else $error("ready flag missing");
    a_cmd_inhibit: assert property (s_cmd |=> INT_INHIBIT == $past(INSTR_DATA[7])) else $error("inhibit wrong");
    a_port_reset: assert property (s_cmd |=> PORT_RESET == ($past(INSTR_DATA[6]) ?
        4'h1 << $past(INSTR_DATA[5:4]) : 4'h0)) else $error("port reset wrong");
    a_xon_release: assert property (s_cmd |=> XON_RELEASE == 4'h1 << $past(INSTR_DATA[5:4]))
        else $error("release pulse wrong");
endmodule
bind qsh_top qsh_top_asserts #(.NCH(NCH)) u_chk (.CLK(CLK), .NRST(NRST), .CE(CE), .STATUS_REQ(STATUS_REQ),
    .STATUS_DATA(STATUS_DATA), .STATUS_VALID(STATUS_VALID), .FW_STATUS(FW_STATUS), .INSTR_WE(INSTR_WE),
    .INSTR_DATA(INSTR_DATA), .CB_READY(CB_READY), .INT_INHIBIT(INT_INHIBIT), .PORT_RESET(PORT_RESET),
    .XON_RELEASE(XON_RELEASE));
`default_nettype wire

// File: qsh_host_model.sv
// host board model: bus clock and baud reference clock
`timescale 1ns/100ps
`default_nettype none
module qsh_host_model (
    output logic bus_clk, // 8 MHz bus clock
    output logic ref_clk  // 3.6864 MHz baud reference
);
    initial begin
        bus_clk = 1'b0;
        forever #62.5 bus_clk = ~bus_clk;
    end
    // phase unrelated to the system clock on purpose
    initial begin
        ref_clk = 1'b0;
        forever #135.6 ref_clk = ~ref_clk;
    end
endmodule
`default_nettype wire

// File: test_qsh_top.sv
// self-checking bench for the quad serial host block
`timescale 1ns/100ps
`default_nettype none
module test_qsh_top;
    logic                    clk, nrst, sreq, svld, iwe, rv, inh, bck, rck;
    logic [7:0]              sdat, idat, rdat;
    logic [3:0]              dsr_n, cbr, prs, xon, rxv, txl, bclk;
    logic [3:0][7:0]         rxd, txd;
    qsh_pkg::qsh_fw_status_s fw;
    qsh_pkg::qsh_reg_req_s   req;
    int                      bad_count, checks_done, c;
    qsh_host_model host (.bus_clk(bck), .ref_clk(rck));
    qsh_top dut (.CLK(clk), .NRST(nrst), .CE(1'b1), .BUS_IO_CLK(bck), .BAUD_REF_CLK(rck), .DSR_N(dsr_n),
        .STATUS_REQ(sreq), .STATUS_DATA(sdat), .STATUS_VALID(svld), .FW_STATUS(fw), .INSTR_WE(iwe),
        .INSTR_DATA(idat), .CB_READY(cbr), .CB_ACK(4'h0), .INT_INHIBIT(inh), .PORT_RESET(prs),
        .XON_RELEASE(xon), .PROC_CLK(), .REG_REQ(req), .REG_RDATA(rdat), .REG_RVALID(rv), .RX_VALID(rxv),
        .RX_DATA(rxd), .TX_DONE(4'h0), .TX_LOAD(txl), .TX_DATA(txd), .LINE_CFG(), .BAUD_CLK(bclk));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic [1:0] ch, input logic [3:0] idx, input logic w, input logic [7:0] d);
        @(negedge clk) req = '{ch, idx, w, !w, d};
        @(negedge clk) req = '0;
        if (!w) chk(rdat, d);
        if (!w) chk({7'h0, rv}, 8'h01);
    endtask
    task automatic stat(input logic [7:0] e);
        @(negedge clk) sreq = 1'b1;
        @(negedge clk) sreq = 1'b0;
        chk(sdat, e);
        chk({7'h0, svld}, 8'h01);
    endtask
    task automatic cmd(input logic [7:0] d, input logic [7:0] e_rdy, input logic [7:0] e_rst, input logic [7:0] e_xon);
        idat = d;
        @(negedge clk) iwe = 1'b1;
        @(negedge clk) iwe = 1'b0;
        chk({4'h0, cbr}, e_rdy);
        chk({4'h0, prs}, e_rst);
        chk({4'h0, xon}, e_xon);
        chk({7'h0, inh}, {7'h0, d[7]});
    endtask
    // one half period of channel A, measured from its next edge
    task automatic half;
        logic b;
        for (int k = 0; k < 2; k++) begin
            b = bclk[0];
            for (c = 0; c < 3000 && bclk[0] === b; c++) @(negedge clk);
        end
        if (c >= 3000) begin
            bad_count++;
            end_sim();
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {nrst, sreq, iwe, idat, rxv, rxd, req, fw, bad_count, checks_done} = '0;
        dsr_n = 4'h5;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        acc(2'd0, qsh_pkg::RI_TCL, 1'b0, 8'h0a);
        acc(2'd0, qsh_pkg::RI_TCH, 1'b0, 8'h00);
        half();
        chk({7'h0, (c inside {[645:658]})}, 8'h01);
        acc(2'd3, qsh_pkg::WI_MISC, 1'b1, 8'h00);
        acc(2'd3, qsh_pkg::WI_TCL, 1'b1, 8'h04);
        acc(2'd3, qsh_pkg::WI_TCH, 1'b1, 8'h8f);
        acc(2'd3, qsh_pkg::RI_TCL, 1'b0, 8'h04);
        acc(2'd3, qsh_pkg::RI_TCH, 1'b0, 8'h8f);
        $display("test divisor done");
        fw = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        stat(8'h55);
        fw = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
        stat(8'h57);
        fw = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        stat(8'h5b);
        $display("test status done");
        acc(2'd2, qsh_pkg::WI_TCL, 1'b1, 8'h55);
        cmd(8'h61, 8'h01, 8'h04, 8'h04);
        acc(2'd2, qsh_pkg::RI_TCL, 1'b0, 8'h0a);
        cmd(8'hb2, 8'h03, 8'h00, 8'h08);
        $display("test command done");
        rxd[0] = 8'h3c;
        rxv = 4'h1;
        @(negedge clk) rxv = 4'h0;
        acc(2'd0, qsh_pkg::RI_STAT, 1'b0, 8'h05);
        acc(2'd0, qsh_pkg::RI_BUF, 1'b0, 8'h3c);
        acc(2'd1, qsh_pkg::WI_BUF, 1'b1, 8'h99);
        chk({4'h0, txl}, 8'h02);
        chk(txd[1], 8'h99);
        $display("test buffer done");
        end_sim();
    end
endmodule
`default_nettype wire
